/* common/charger_pkg.sv */
// Shared constants for the charger control and I2C status block
//
// Overview of operation
// - Battery below 3.0 V keeps the charger in pre-charge at low current.
// - Full charge runs constant current, then constant voltage until current tapers.
// - Regulation voltage comes from four temperature band settings; current is halved below 10 or above 45 degrees.
// - Charging stops below 0 or above 60 degrees, resuming above 10 or below 50 degrees.
// - Off until enable high and supply above upper threshold; off below lower.
// - Inductor current limit ends the present switching cycle early.
// - Over-temperature tri-states the switch node until cool-down, then restarts.
// - Battery 2 percent above termination voltage shuts charging down as fault.
// - Overvoltage, temperature out of range or full-charge timeout stop charging, fault low.
// - Once a fault clears, return to initialize; fault output low until status read.
// - After status read clears faults, release fault output until a new fault.
// - Open thermistor, shutdown, undervoltage, top-off timeout stop charging, set status.
// - Warnings set status bits but never pull the fault output low.
// - Status read clears every bit whose condition is gone; fault output released once fault bits clear.
// - I2C slave for standard and fast mode with auto-incrementing register address.
// - START and STOP are SDA edges while SCL is high; slave detects both.
// - On matching address the slave holds SDA low through the acknowledge clock.
// - SDA stable while SCL high; any such change is a START or STOP.
// - Bytes are eight bits plus acknowledge; slave receiver acknowledges every byte.
// - Master reader leaves last byte unacknowledged; slave then releases SDA.
// - Transmitter releases SDA before the acknowledge bit.
// - The slave answers only to seven-bit address 0x48.
// - Status register is read-only; bus writes leave it unchanged.
package charger_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int SW_FREQ_HZ = 1_000_000;
   localparam int DUTY_MAX_PCT = 98;
   localparam int PWM_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
   localparam int PWM_ON_CYC = (PWM_PERIOD_CYC * DUTY_MAX_PCT) / 100;
   localparam int TIMER_TICK_S = 1;
   localparam int TIMER_TICK_CYC = CLK_HZ * TIMER_TICK_S;

   localparam logic [6:0] SLAVE_ADDR = 7'h48;

   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CFG1 = 8'h02;
   localparam logic [7:0] OFS_CFG2 = 8'h03;
   localparam logic [7:0] OFS_CFG3 = 8'h04;
   localparam logic [7:0] OFS_CFG4 = 8'h05;
   localparam logic [7:0] OFS_CFG5 = 8'h06;
   localparam logic [7:0] OFS_CFG_EN = 8'h11;
   localparam logic [7:0] OFS_EEP_CTRL = 8'h12;

   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_CFG_EN = 8'h00;
   localparam logic [7:0] RST_EEP_CTRL = 8'h00;
   localparam logic [7:0] RST_TIMER_LIMIT = 8'h0a;

   // Status bit positions
   localparam int ST_BATT_OV = 7;
   localparam int ST_FC_TO = 6;
   localparam int ST_TEMP_0C = 5;
   localparam int ST_TEMP_60C = 4;
   localparam int ST_TSD = 3;
   localparam int ST_TOP_TO = 2;
   localparam int ST_VIN_UV = 1;
   localparam int ST_TH_OPEN = 0;

   // Field positions of the first two configuration registers
   localparam int CF_PRE_LSB = 6;
   localparam int CF_VHI_LSB = 3;
   localparam int CF_VLO_LSB = 0;

   typedef enum logic [2:0] {
      CH_OFF, CH_INIT, CH_PRE, CH_CC, CH_CV, CH_DONE
   } chg_state_t;
endpackage

/* rtl/charger_fault_i2c_ctrl.sv */
// Charger sequencer, protection, status register and I2C slave
`timescale 1ns/1ps
module charger_fault_i2c_ctrl
   import charger_pkg::*;
#(
   parameter int TIMER_TICK = TIMER_TICK_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Enable and supply comparators
   input wire logic enable_i,
   input wire logic supply_input_hi_i,
   input wire logic supply_input_lo_i,
   // Battery comparators
   input wire logic bat_below_pre_i,
   input wire logic bat_at_term_i,
   input wire logic bat_over_i,
   input wire logic chg_taper_i,
   // Thermistor comparators
   input wire logic th_open_i,
   input wire logic th_below0_i,
   input wire logic th_below10_i,
   input wire logic th_above45_i,
   input wire logic th_above50_i,
   input wire logic th_above60_i,
   // Die temperature and current limit
   input wire logic tsd_trip_i,
   input wire logic tsd_cool_i,
   input wire logic switch_overcurrent_limit_i,
   // Switch node
   output logic switch_node_out_o,
   output logic switch_node_out_oe_o,
   // Regulation settings
   output logic [2:0] chg_mode_o,
   output logic [1:0] pre_current_o,
   output logic [2:0] vreg_code_o,
   output logic [7:0] cc_code_o,
   // Fault pin, open drain
   output logic fault_n_out_o,
   output logic fault_n_out_oe_o,
   // I2C pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   localparam int NSYNC = 16;

   typedef enum {
      I_IDLE, I_ADDR, I_ADDR_ACK, I_WR, I_WR_ACK, I_RD, I_RD_ACK
   } i2c_state_t;

   logic [NSYNC-1:0] sync_lvl;
   logic en_s, vhi_s, vlo_s, blow_s, bterm_s, bov_s, taper_s;
   logic thopen_s, b0_s, b10_s, a45_s, a50_s, a60_s;
   logic tsdt_s, tsdc_s, ocl_s, scl_s, sda_s;

   pin_sync #(.WIDTH(NSYNC)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i({enable_i, supply_input_hi_i, supply_input_lo_i,
                bat_below_pre_i, bat_at_term_i, bat_over_i, chg_taper_i,
                th_open_i, th_below0_i, th_below10_i, th_above45_i,
                th_above50_i, th_above60_i, tsd_trip_i, tsd_cool_i,
                switch_overcurrent_limit_i}),
      .level_o(sync_lvl)
   );
   assign {en_s, vhi_s, vlo_s, blow_s, bterm_s, bov_s, taper_s, thopen_s,
           b0_s, b10_s, a45_s, a50_s, a60_s, tsdt_s, tsdc_s,
           ocl_s} = sync_lvl;

   // SCL and SDA idle high, so their filters are kept apart with a high reset
   logic sd1_r, sd2_r, sd3_r, sda_r;
   logic sc1_r, sc2_r, sc3_r, scl_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sd1_r <= 1'b1;
         sd2_r <= 1'b1;
         sd3_r <= 1'b1;
         sda_r <= 1'b1;
         sc1_r <= 1'b1;
         sc2_r <= 1'b1;
         sc3_r <= 1'b1;
         scl_r <= 1'b1;
      end else begin
         sd1_r <= sda_i;
         sd2_r <= sd1_r;
         sd3_r <= sd2_r;
         if (sd2_r == sd3_r) begin
            sda_r <= sd3_r;
         end
         sc1_r <= scl_i;
         sc2_r <= sc1_r;
         sc3_r <= sc2_r;
         if (sc2_r == sc3_r) begin
            scl_r <= sc3_r;
         end
      end
   end
   assign sda_s = sda_r;
   assign scl_s = scl_r;

   // Configuration storage
   logic [7:0] cfg_r [5];
   logic [7:0] cfg_en_r, eep_ctrl_r;
   logic [7:0] status_r;
   logic wr_stb, rd_clr;
   logic [7:0] sub_r, shift_r;

   // Powered state with supply hysteresis
   logic power_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_r <= 1'b0;
      end else if (!en_s || vlo_s) begin
         power_r <= 1'b0;
      end else if (vhi_s) begin
         power_r <= 1'b1;
      end
   end

   // Temperature latches with hysteresis, and die shutdown latch
   logic cold_r, hot_r, tsd_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cold_r <= 1'b0;
         hot_r <= 1'b0;
      end else begin
         if (b0_s) begin
            cold_r <= 1'b1;
         end else if (!b10_s) begin
            cold_r <= 1'b0;
         end
         if (a60_s) begin
            hot_r <= 1'b1;
         end else if (!a50_s) begin
            hot_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tsd_r <= 1'b0;
      end else if (tsdt_s) begin
         tsd_r <= 1'b1;
      end else if (tsdc_s) begin
         tsd_r <= 1'b0;
      end
   end

   // Phase timers; timeouts hold until the charger is switched off
   chg_state_t state_r, state_nxt;
   logic fc_exp, top_exp, fc_to_r, top_to_r;

   phase_timer #(.TICK_CYC(TIMER_TICK)) u_fc_tmr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(state_r == CH_CC || state_r == CH_CV),
      .limit_i(cfg_r[2]),
      .expired_o(fc_exp)
   );
   phase_timer #(.TICK_CYC(TIMER_TICK)) u_top_tmr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(state_r == CH_CV),
      .limit_i(cfg_r[3]),
      .expired_o(top_exp)
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fc_to_r <= 1'b0;
         top_to_r <= 1'b0;
      end else if (!power_r) begin
         fc_to_r <= 1'b0;
         top_to_r <= 1'b0;
      end else begin
         fc_to_r <= fc_to_r | fc_exp;
         top_to_r <= top_to_r | top_exp;
      end
   end

   logic fault_cond, warn_cond, vin_uv;
   assign vin_uv = en_s && !power_r && !vhi_s;
   assign fault_cond = bov_s | cold_r | hot_r | fc_to_r;
   assign warn_cond = thopen_s | tsd_r | top_to_r;

   // Return to initialize while any condition is present
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         CH_OFF: if (power_r) state_nxt = CH_INIT;
         CH_INIT: if (!fault_cond && !warn_cond) state_nxt = CH_PRE;
         CH_PRE: if (!blow_s) state_nxt = CH_CC;
         CH_CC: if (bterm_s) state_nxt = CH_CV;
         CH_CV: if (taper_s) state_nxt = CH_DONE;
         CH_DONE: if (blow_s) state_nxt = CH_PRE;
      endcase
      if (state_r != CH_OFF && (fault_cond || warn_cond)) begin
         state_nxt = CH_INIT;
      end
      if (!power_r) begin
         state_nxt = CH_OFF;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= CH_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vreg_code_o <= 3'h0;
         cc_code_o <= 8'h00;
         pre_current_o <= 2'h0;
         chg_mode_o <= 3'h0;
      end else begin
         if (b10_s) begin
            vreg_code_o <= cfg_r[0][CF_VHI_LSB +: 3];
         end else if (a50_s) begin
            vreg_code_o <= cfg_r[1][CF_VLO_LSB +: 3];
         end else if (a45_s) begin
            vreg_code_o <= cfg_r[1][CF_VHI_LSB +: 3];
         end else begin
            vreg_code_o <= cfg_r[0][CF_VLO_LSB +: 3];
         end
         cc_code_o <= (b10_s || a45_s) ? (cfg_r[4] >> 1) : cfg_r[4];
         pre_current_o <= cfg_r[0][CF_PRE_LSB +: 2];
         chg_mode_o <= state_r;
      end
   end

   // Switching cycle with early end on current limit
   logic [4:0] pwm_cnt_r;
   logic cut_r, reg_on;
   assign reg_on = (state_r == CH_PRE || state_r == CH_CC ||
                    state_r == CH_CV);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_cnt_r <= 5'h00;
         cut_r <= 1'b0;
         switch_node_out_o <= 1'b0;
         switch_node_out_oe_o <= 1'b0;
      end else begin
         if (pwm_cnt_r == 5'(PWM_PERIOD_CYC - 1)) begin
            pwm_cnt_r <= 5'h00;
            cut_r <= 1'b0;
         end else begin
            pwm_cnt_r <= pwm_cnt_r + 5'h01;
            if (ocl_s) begin
               cut_r <= 1'b1;
            end
         end
         switch_node_out_o <= reg_on && !cut_r && !ocl_s &&
                              (pwm_cnt_r < 5'(PWM_ON_CYC));
         switch_node_out_oe_o <= reg_on && !tsd_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_r <= RST_STATUS;
      end else begin
         status_r <= (rd_clr ? 8'h00 : status_r) |
                     {bov_s, fc_to_r, cold_r, hot_r,
                      tsd_r, top_to_r, vin_uv, thopen_s};
      end
   end

   // Fault pin follows fault bits only
   assign fault_n_out_o = 1'b0;
   assign fault_n_out_oe_o = |status_r[ST_BATT_OV:ST_TEMP_60C];

   function automatic logic [7:0] reg_read(input logic [7:0] a,
                                           input logic [7:0] st);
      unique case (a)
         OFS_STATUS: reg_read = st;
         OFS_CFG1: reg_read = cfg_r[0];
         OFS_CFG2: reg_read = cfg_r[1];
         OFS_CFG3: reg_read = cfg_r[2];
         OFS_CFG4: reg_read = cfg_r[3];
         OFS_CFG5: reg_read = cfg_r[4];
         OFS_CFG_EN: reg_read = cfg_en_r;
         OFS_EEP_CTRL: reg_read = eep_ctrl_r;
         default: reg_read = 8'h00;
      endcase
   endfunction

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 5; i++) begin
            cfg_r[i] <= RST_CFG;
         end
         cfg_r[2] <= RST_TIMER_LIMIT;
         cfg_r[3] <= RST_TIMER_LIMIT;
         cfg_en_r <= RST_CFG_EN;
         eep_ctrl_r <= RST_EEP_CTRL;
      end else if (wr_stb) begin
         if (sub_r >= OFS_CFG1 && sub_r <= OFS_CFG5) begin
            cfg_r[3'(sub_r - OFS_CFG1)] <= shift_r;
         end
         if (sub_r == OFS_CFG_EN) cfg_en_r <= shift_r;
         if (sub_r == OFS_EEP_CTRL) eep_ctrl_r <= shift_r;
      end
   end

   // I2C slave
   i2c_state_t i_st_r;
   logic scl_d_r, sda_d_r, rw_r, first_r, mnack_r;
   logic [3:0] bit_r;
   logic [7:0] tx_r;
   logic [7:0] rd_byte;
   logic scl_rise, scl_fall, start_c, stop_c;

   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign wr_stb = scl_fall && i_st_r == I_WR && bit_r == 4'h8 &&
                   !first_r;
   assign rd_clr = scl_fall && sub_r == OFS_STATUS &&
                   ((i_st_r == I_ADDR_ACK && rw_r) ||
                    (i_st_r == I_RD_ACK && !mnack_r));
   assign sda_o = 1'b0;

   // Byte to be sent from the current subaddress
   always_comb begin
      rd_byte = reg_read(sub_r, status_r);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         i_st_r <= I_IDLE;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         sda_oe_o <= 1'b0;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         sub_r <= 8'h00;
         rw_r <= 1'b0;
         first_r <= 1'b0;
         mnack_r <= 1'b0;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         if (start_c) begin
            i_st_r <= I_ADDR;
            bit_r <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop_c) begin
            i_st_r <= I_IDLE;
            sda_oe_o <= 1'b0;
         end else if (scl_rise) begin
            // Address and data shift MSB first
            if (i_st_r == I_ADDR || i_st_r == I_WR) begin
               shift_r <= {shift_r[6:0], sda_s};
               bit_r <= bit_r + 4'h1;
            end
            if (i_st_r == I_RD_ACK) mnack_r <= sda_s;
         end else if (scl_fall) begin
            unique case (i_st_r)
               I_IDLE: ;
               I_ADDR: if (bit_r == 4'h8) begin
                  if (shift_r[7:1] == SLAVE_ADDR) begin
                     i_st_r <= I_ADDR_ACK;
                     sda_oe_o <= 1'b1;
                     rw_r <= shift_r[0];
                  end else begin
                     i_st_r <= I_IDLE;
                  end
               end
               I_ADDR_ACK: begin
                  bit_r <= 4'h0;
                  if (rw_r) begin
                     tx_r <= rd_byte;
                     sda_oe_o <= !rd_byte[7];
                     sub_r <= sub_r + 8'h01;
                     i_st_r <= I_RD;
                  end else begin
                     sda_oe_o <= 1'b0;
                     first_r <= 1'b1;
                     i_st_r <= I_WR;
                  end
               end
               I_WR: if (bit_r == 4'h8) begin
                  sda_oe_o <= 1'b1;
                  i_st_r <= I_WR_ACK;
                  first_r <= 1'b0;
                  sub_r <= first_r ? shift_r : sub_r + 8'h01;
               end
               I_WR_ACK: begin
                  sda_oe_o <= 1'b0;
                  bit_r <= 4'h0;
                  i_st_r <= I_WR;
               end
               I_RD: if (bit_r == 4'h7) begin
                  sda_oe_o <= 1'b0;
                  i_st_r <= I_RD_ACK;
               end else begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  sda_oe_o <= !tx_r[6];
                  bit_r <= bit_r + 4'h1;
               end
               I_RD_ACK: begin
                  bit_r <= 4'h0;
                  if (mnack_r) begin
                     sda_oe_o <= 1'b0;
                     i_st_r <= I_IDLE;
                  end else begin
                     tx_r <= rd_byte;
                     sda_oe_o <= !rd_byte[7];
                     sub_r <= sub_r + 8'h01;
                     i_st_r <= I_RD;
                  end
               end
            endcase
         end
      end
   end
endmodule // charger_fault_i2c_ctrl

/* rtl/phase_timer.sv */
// Prescaled timeout counter for one charging phase
`timescale 1ns/1ps
module phase_timer #(
   parameter int TICK_CYC = 20_000_000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic run_i,
   input wire logic [7:0] limit_i,
   output logic expired_o
);
   logic [31:0] pre_r;
   logic [7:0] cnt_r;
   logic tick;

   assign tick = (pre_r == 32'(TICK_CYC - 1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_r <= 32'h0;
         cnt_r <= 8'h00;
      end else if (!run_i) begin
         pre_r <= 32'h0;
         cnt_r <= 8'h00;
      end else begin
         pre_r <= tick ? 32'h0 : pre_r + 32'h1;
         if (tick && !expired_o) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   assign expired_o = run_i && (cnt_r >= limit_i);
endmodule // phase_timer

/* rtl/pin_sync.sv */
// Three-stage synchroniser with agreement filter for external inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pins and filtered levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_r, s2_r, s3_r, lvl_r;
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               lvl_r <= 1'b0;
            end else begin
               s1_r <= async_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign level_o[g] = lvl_r;
      end
   endgenerate
endmodule // pin_sync

/* verification/charger_assertions.sv */
// Port checker for the charger controller
`timescale 1ns/1ps
module charger_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Watched inputs
   input wire logic enable_i,
   input wire logic bat_over_i,
   input wire logic tsd_trip_i,
   input wire logic switch_overcurrent_limit_i,
   input wire logic scl_i,
   // Watched outputs
   input wire logic switch_node_out_o,
   input wire logic switch_node_out_oe_o,
   input wire logic [2:0] chg_mode_o,
   input wire logic fault_n_out_o,
   input wire logic fault_n_out_oe_o,
   input wire logic sda_o,
   input wire logic sda_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_fault_pin_low: assert property (fault_n_out_oe_o
      |-> !fault_n_out_o)
      else $error("fault pin driven high");
   a_sda_drive_low: assert property (sda_oe_o |-> !sda_o)
      else $error("data line driven high");
   a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line moved while clock high");
   a_release_on_read: assert property ($fell(fault_n_out_oe_o)
      |-> !scl_i)
      else $error("fault pin released outside a read");
   a_sw_idle_off: assert property ((chg_mode_o <= 3'h1)
      && ($past(chg_mode_o) <= 3'h1) |-> !switch_node_out_oe_o)
      else $error("switch node driven while idle");
   a_ocl_cut: assert property (switch_overcurrent_limit_i[*8]
      |-> !(switch_node_out_o && $past(switch_node_out_o)))
      else $error("on-time not cut by current limit");
   a_tsd_tristate: assert property (tsd_trip_i[*8]
      |-> !switch_node_out_oe_o)
      else $error("switch node driven in shutdown");
   a_enable_off: assert property ((!enable_i)[*8]
      |-> chg_mode_o == 3'h0)
      else $error("charger not off while disabled");
   a_ov_fault_pin: assert property (bat_over_i[*8]
      |-> fault_n_out_oe_o)
      else $error("fault pin not pulled on overvoltage");
   c_fault: cover property ($rose(fault_n_out_oe_o));
   c_cv: cover property (chg_mode_o == 3'h4);
   c_ack: cover property ($rose(sda_oe_o));
   c_ocl: cover property (switch_overcurrent_limit_i && chg_mode_o == 3'h3);
endmodule // charger_checker

bind charger_fault_i2c_ctrl charger_checker chk (.clk_i, .rst_n_i,
   .enable_i, .tsd_trip_i, .switch_overcurrent_limit_i, .scl_i, .bat_over_i,
   .switch_node_out_o, .switch_node_out_oe_o, .chg_mode_o, .fault_n_out_o,
   .fault_n_out_oe_o, .sda_o, .sda_oe_o);

/* verification/charger_fault_i2c_ctrl_test.sv */
// Self-checking bench for the charger controller
`timescale 1ns/1ps
module charger_fault_i2c_ctrl_test;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic enable_i = 1'b1;
   logic bat_below_pre_i = 1'b1;
   logic ocl = 1'b0;
   logic [5:0] ev = 6'h0;
   logic sda_low, sda_o, sda_oe_o, sw_oe, flt_oe, a;
   logic term = 1'b0;
   logic b10 = 1'b0;
   logic [2:0] vreg;
   logic [7:0] cc;
   logic [2:0] mode;
   logic [1:0] pre;
   logic [7:0] d0, d1;
   wire scl;
   wire sda = !((sda_oe_o && !sda_o) || sda_low);
   int fail_count = 0;
   int num_checks = 0;
   localparam logic [7:0] EXP [0:5] = '{8'h80, 8'h20, 8'h10, 8'h01, 8'h08, 8'h02};
   localparam logic [5:0] FL = 6'b000111;
   charger_fault_i2c_ctrl #(.TIMER_TICK(4)) DUT (.clk_i, .rst_n_i, .enable_i,
      .supply_input_hi_i(!ev[5]), .supply_input_lo_i(ev[5]), .bat_below_pre_i,
      .bat_at_term_i(term), .bat_over_i(ev[0]), .chg_taper_i(1'b0),
      .th_open_i(ev[3]), .th_below0_i(ev[1]), .th_below10_i(b10),
      .th_above45_i(1'b0), .th_above50_i(1'b0), .th_above60_i(ev[2]),
      .tsd_trip_i(ev[4]), .tsd_cool_i(!ev[4]), .switch_overcurrent_limit_i(ocl),
      .switch_node_out_o(), .switch_node_out_oe_o(sw_oe), .chg_mode_o(mode),
      .pre_current_o(pre), .vreg_code_o(vreg), .cc_code_o(cc),
      .fault_n_out_o(),
      .fault_n_out_oe_o(flt_oe), .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o);
   i2c_host_model m (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
   always #25 clk_i = ~clk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr(input logic [7:0] s, d, input int n);
      m.start();
      m.wbyte(8'h90, a);
      chk(a, 1'b1);
      m.wbyte(s, a);
      chk(a, 1'b1);
      if (n > 0) m.wbyte(d, a);
      chk(a, 1'b1);
      m.stop();
   endtask
   task automatic rd(input logic [7:0] s);
      wr(s, 8'h00, 0);
      m.start();
      m.wbyte(8'h91, a);
      chk(a, 1'b1);
      m.rbyte(d0, 1'b0);
      m.rbyte(d1, 1'b1);
      m.stop();
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (num_checks > 0 && fail_count == 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #3_000_000;
      fail_count++;
      end_of_test();
   end
   initial begin
      tick(2);
      rst_n_i = 1'b1;
      tick(20);
      chk(mode, 3'h2);
      rd(8'h00);
      chk(d0, 8'h00);
      wr(8'h02, 8'ha5, 1);
      wr(8'h03, 8'h3c, 1);
      rd(8'h02);
      chk(d0, 8'ha5);
      chk(d1, 8'h3c);
      chk(pre, 2'h2);
      chk(vreg, 3'h5);
      wr(8'h06, 8'h40, 1);
      b10 = 1'b1;
      tick(12);
      chk(vreg, 3'h4);
      chk(cc, 8'h20);
      b10 = 1'b0;
      tick(12);
      chk(cc, 8'h40);
      m.stretch = 2000;
      wr(8'h00, 8'hff, 1);
      rd(8'h00);
      chk(d0, 8'h00);
      m.stretch = 0;
      m.start();
      m.wbyte(8'h92, a);
      m.stop();
      chk(a, 1'b0);
      for (int i = 0; i < 6; i++) begin
         chk(sw_oe, 1'b1);
         ev[i] = 1'b1;
         tick(12);
         chk(sw_oe, 1'b0);
         ev[i] = 1'b0;
         tick(12);
         chk(flt_oe, FL[i]);
         rd(8'h00);
         chk(d0, EXP[i]);
         chk(flt_oe, 1'b0);
      end
      bat_below_pre_i = 1'b0;
      tick(12);
      chk(mode, 3'h3);
      ocl = 1'b1;
      tick(10);
      ocl = 1'b0;
      term = 1'b1;
      tick(10);
      chk(mode, 3'h4);
      tick(50);
      chk(flt_oe, 1'b1);
      bat_below_pre_i = 1'b1;
      term = 1'b0;
      enable_i = 1'b0;
      tick(10);
      chk(mode, 3'h0);
      enable_i = 1'b1;
      tick(20);
      chk(flt_oe, 1'b1);
      rd(8'h00);
      chk(d0 & 8'hf0, 8'h40);
      chk(flt_oe, 1'b0);
      end_of_test();
   end
endmodule // charger_fault_i2c_ctrl_test

/* verification/i2c_host_model.sv */
// Behavioural bus master for the serial port
`timescale 1ns/1ps
module i2c_host_model (
   // Bus lines
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   localparam int T = 400;
   int stretch = 0;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic pulse(input logic b, output logic r);
      scl_o = 1'b0;
      #(2*T+stretch);
      sda_low_o = !b;
      #(2*T);
      scl_o = 1'b1;
      #T;
      r = sda_i;
      #T;
      scl_o = 1'b0;
   endtask
   task automatic start;
      sda_low_o = 1'b0;
      #(2*T);
      scl_o = 1'b1;
      #T;
      sda_low_o = 1'b1;
      #T;
      scl_o = 1'b0;
   endtask
   task automatic stop;
      #(2*T);
      sda_low_o = 1'b1;
      #(2*T);
      scl_o = 1'b1;
      #T;
      sda_low_o = 1'b0;
      #(2*T);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) pulse(d[i], r);
      pulse(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, r);
         d[i] = r;
      end
      pulse(last, r);
   endtask
endmodule // i2c_host_model
